// ===== bench/sagen_bcu_model.sv
/*
  bus control unit stand-in: latches each physical address handed over.
  assumes answers come as one-cycle valid pulses.
*/
`timescale 1ns/1ps
`default_nettype none
module sagen_bcu_model (
  input  wire logic                     clk_i,
  input  wire logic                     rst_n_i,
  input  wire sagen_pkg::sagen_ans_type ans_i,
  output logic [19:0]                   phys_o
);
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i)
      phys_o <= 20'h0;
    else if (ans_i.valid)
      phys_o <= ans_i.phys;
  end
endmodule
`default_nettype wire

// ===== bench/sagen_properties.sv
/*
  checker for the segment address generator, bound to sagen_top.
  assumes one request per cycle and the answer one clock after it.
*/
`timescale 1ns/1ps
`default_nettype none
module sagen_properties (
  input wire logic                      clk_i,
  input wire logic                      rst_n_i,
  input wire sagen_pkg::sagen_req_type  req_i,
  input wire sagen_pkg::sagen_regs_type regs_i,
  input wire sagen_pkg::sagen_segs_type segs_i,
  input wire sagen_pkg::sagen_ans_type  ans_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  wire logic [2:0] k = req_i.kind;
  wire logic       v = req_i.valid;
  // frame-based operand offset
  wire logic       fb = req_i.modrm[2:1] == 2'h1 || (req_i.modrm[2:0] == 3'h6 && ^req_i.modrm[7:6]);
  sagen_pkg::sagen_segs_type prev_segs;
  logic [15:0]               sv;
  always_ff @(posedge clk_i) prev_segs <= segs_i;
  always_comb begin
    case (ans_o.seg)
      sagen_pkg::SEG_CODE:  sv = prev_segs.code_seg_base;
      sagen_pkg::SEG_STACK: sv = prev_segs.stack_seg_base;
      sagen_pkg::SEG_DATA0: sv = prev_segs.data0_seg_base;
      default:              sv = prev_segs.data1_seg_base;
    endcase
  end
  a_answer_follows: assert property (v |=> ans_o.valid) else $error("answer missing");
  a_no_spurious: assert property (!v |=> !ans_o.valid) else $error("answer without request");
  a_fetch_code: assert property (v && k == 3'h0 |=> ans_o.seg == sagen_pkg::SEG_CODE &&
    ans_o.offset == $past(regs_i.fetch_pointer)) else $error("fetch segment wrong");
  a_stack_ptr: assert property (v && k == 3'h1 |=> ans_o.seg == sagen_pkg::SEG_STACK &&
    ans_o.offset == $past(regs_i.stack_top_offset)) else $error("stack segment wrong");
  a_dest_data1: assert property (v && k == 3'h4 |=> ans_o.seg == sagen_pkg::SEG_DATA1 &&
    ans_o.offset == $past(regs_i.dest_index_reg)) else $error("destination segment wrong");
  a_src_default: assert property (v && k == 3'h3 && !req_i.ovr_valid |=> ans_o.seg == sagen_pkg::SEG_DATA0 &&
    ans_o.offset == $past(regs_i.source_index_reg)) else $error("source segment wrong");
  a_operand_default: assert property (v && k == 3'h2 && !req_i.ovr_valid |=>
    ans_o.seg == ($past(fb) ? sagen_pkg::SEG_STACK : sagen_pkg::SEG_DATA0)) else $error("operand default wrong");
  a_override_taken: assert property (v && (k == 3'h2 || k == 3'h3) && req_i.ovr_valid |=>
    ans_o.seg == $past(req_i.ovr_seg)) else $error("override not applied");
  a_phys_sum: assert property (ans_o.valid |-> ans_o.phys == {sv, 4'h0} + {4'h0, ans_o.offset})
    else $error("physical address wrong");
  a_answer_hold: assert property (!v |=> $stable(ans_o.phys) && $stable(ans_o.seg) && $stable(ans_o.offset))
    else $error("answer not held");
endmodule
bind sagen_top sagen_properties u_props (.clk_i(clk_i), .rst_n_i(rst_n_i), .req_i(req_i), .regs_i(regs_i),
  .segs_i(segs_i), .ans_o(ans_o));
`default_nettype wire

// ===== bench/test_sagen_top.sv
/*
  testbench for sagen_top: one request at a time, answer checked a clock later.
  assumes the checker is bound by its own file.
*/
`timescale 1ns/1ps
`default_nettype none
module test_sagen_top;
  logic                      clk_i = 1'b0;
  logic                      rst_n_i = 1'b0;
  sagen_pkg::sagen_req_type  req_i = '0;
  sagen_pkg::sagen_regs_type regs_i = {16'h0010, 16'h0100, 16'h0003, 16'h0005, 16'h0ffe, 16'h0200};
  sagen_pkg::sagen_segs_type segs_i = {16'h1000, 16'h2000, 16'h3000, 16'h4000};
  sagen_pkg::sagen_ans_type  ans_o;
  logic [19:0]               bcu_phys;
  logic [15:0]               sb [4] = '{16'h4000, 16'h1000, 16'h2000, 16'h3000};
  int                        err_count = 0;
  int                        checks = 0;
  sagen_top DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .req_i(req_i), .regs_i(regs_i), .segs_i(segs_i), .ans_o(ans_o));
  sagen_bcu_model u_bcu (.clk_i(clk_i), .rst_n_i(rst_n_i), .ans_i(ans_o), .phys_o(bcu_phys));
  task automatic chk(input logic [19:0] s, input logic [19:0] e);
    checks++;
    if (s !== e) begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic t(input logic [2:0] k, input logic [7:0] m, input logic [15:0] d, input logic ov,
                   input logic [1:0] os, input logic [1:0] es, input logic [15:0] eo);
    @(posedge clk_i);
    #1;
    req_i = {1'b1, k, m, d, ov, os};
    @(posedge clk_i);
    #1;
    chk(20'(ans_o.valid), 20'h1);
    chk(20'(ans_o.seg), 20'(es));
    chk(20'(ans_o.offset), 20'(eo));
    chk(ans_o.phys, {sb[es], 4'h0} + 20'(eo));
  endtask
  task automatic t_fixed();
    t(3'h0, 8'h00, 16'h0, 1'b1, 2'h3, 2'h1, 16'h0200);
    t(3'h1, 8'h00, 16'h0, 1'b1, 2'h0, 2'h2, 16'h0ffe);
    t(3'h4, 8'h00, 16'h0, 1'b1, 2'h1, 2'h0, 16'h0005);
  endtask
  task automatic t_source();
    t(3'h3, 8'h00, 16'h0, 1'b0, 2'h0, 2'h3, 16'h0003);
    for (int i = 0; i < 4; i++) t(3'h3, 8'h00, 16'h0, 1'b1, 2'(i), 2'(i), 16'h0003);
  endtask
  task automatic t_operand();
    t(3'h2, 8'h46, 16'h0002, 1'b0, 2'h0, 2'h2, 16'h0102);
    t(3'h2, 8'h46, 16'h0002, 1'b1, 2'h3, 2'h3, 16'h0102);
    t(3'h2, 8'h46, 16'h0002, 1'b1, 2'h1, 2'h1, 16'h0102);
    t(3'h2, 8'h00, 16'h0000, 1'b0, 2'h0, 2'h3, 16'h0013);
    t(3'h2, 8'h06, 16'h1234, 1'b0, 2'h0, 2'h3, 16'h1234);
    t(3'h2, 8'h40, 16'h00ff, 1'b0, 2'h0, 2'h3, 16'h0012);
    t(3'h2, 8'h80, 16'h1000, 1'b0, 2'h0, 2'h3, 16'h1013);
    t(3'h2, 8'h43, 16'h0080, 1'b0, 2'h0, 2'h2, 16'h0085);
    t(3'h2, 8'h87, 16'hffff, 1'b0, 2'h0, 2'h3, 16'h000f);
    t(3'h2, 8'hc6, 16'h1234, 1'b0, 2'h0, 2'h3, 16'h1234);
  endtask
  task automatic t_wrap();
    segs_i.data1_seg_base = 16'hffff;
    sb[0] = 16'hffff;
    regs_i.dest_index_reg = 16'h0020;
    t(3'h4, 8'h00, 16'h0, 1'b0, 2'h0, 2'h0, 16'h0020);
    req_i.valid = 1'b0;
    repeat (2) @(posedge clk_i);
    #1;
    chk(20'(ans_o.valid), 20'h0);
    chk(ans_o.phys, 20'h00010);
    chk(bcu_phys, 20'h00010);
  endtask
  task automatic t_reset();
    @(posedge clk_i);
    #1;
    rst_n_i = 1'b0;
    req_i.valid = 1'b0;
    @(posedge clk_i);
    #1;
    chk(20'(ans_o.valid), 20'h0);
    chk(ans_o.phys, 20'h0);
    chk(bcu_phys, 20'h0);
    rst_n_i = 1'b1;
    t(3'h0, 8'h00, 16'h0, 1'b0, 2'h0, 2'h1, 16'h0200);
  endtask
  task automatic finish_test();
    $display("checks=%0d err_count=%0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  initial begin
    #20000;
    err_count++;
    finish_test();
  end
  initial begin
    repeat (2) @(posedge clk_i);
    #1;
    rst_n_i = 1'b1;
    chk(20'(ans_o.valid), 20'h0);
    chk(ans_o.phys, 20'h0);
    t_fixed();
    t_source();
    t_operand();
    t_wrap();
    t_reset();
    finish_test();
  end
endmodule
`default_nettype wire

// ===== hw/sagen_offset.sv
/*
  operand offset adder: decodes the addressing-mode byte and sums
  displacement, base and index. purely combinational.
  assumes register values are stable while the request is presented.
*/
`timescale 1ns/1ps
`default_nettype none
module sagen_offset (
  // request
  input  wire logic [7:0]  modrm_i,
  input  wire logic [15:0] disp_i,
  // register file
  input  wire sagen_pkg::sagen_regs_type regs_i,
  // result
  output logic [15:0]      offset_o,
  output logic             frame_based_o
);
  logic [15:0] base_term;
  logic [15:0] index_term;
  logic [15:0] disp_term;
  logic [1:0]  mode;
  logic [2:0]  rm;

  // ----------------------------------------------------------------
  // term selection
  // ----------------------------------------------------------------
  always_comb begin
    mode = modrm_i[sagen_pkg::MOD_HI:sagen_pkg::MOD_LO]; // R11
    rm = modrm_i[sagen_pkg::RM_HI:sagen_pkg::RM_LO];
    base_term = 16'h0000;
    index_term = 16'h0000;
    frame_based_o = 1'b0;
    unique case (rm)
      3'h0: begin
        base_term = regs_i.base_reg;
        index_term = regs_i.source_index_reg;
      end
      3'h1: begin
        base_term = regs_i.base_reg;
        index_term = regs_i.dest_index_reg;
      end
      3'h2: begin
        base_term = regs_i.frame_base_reg;
        index_term = regs_i.source_index_reg;
        frame_based_o = 1'b1;
      end
      3'h3: begin
        base_term = regs_i.frame_base_reg;
        index_term = regs_i.dest_index_reg;
        frame_based_o = 1'b1;
      end
      3'h4: index_term = regs_i.source_index_reg;
      3'h5: index_term = regs_i.dest_index_reg;
      3'h6: begin
        // register mode acts like no displacement: direct, not frame based
        if (mode == sagen_pkg::MOD_DISP8 || mode == sagen_pkg::MOD_DISP16) begin // R11 R5
          base_term = regs_i.frame_base_reg;
          frame_based_o = 1'b1;
        end
      end
      3'h7: base_term = regs_i.base_reg;
    endcase
    // 8-bit displacement sign-extended, 16-bit taken whole
    unique case (mode)
      sagen_pkg::MOD_DISP8:  disp_term = {{8{disp_i[7]}}, disp_i[7:0]}; // R13
      sagen_pkg::MOD_DISP16: disp_term = disp_i; // R13
      default:               disp_term = (rm == sagen_pkg::RM_DIRECT) ? disp_i : 16'h0000;
    endcase
    offset_o = 16'(disp_term + base_term + index_term); // R12 R18 R10
  end
endmodule
`default_nettype wire

// ===== hw/sagen_top.sv
/*
  segment address generator: picks the segment for each memory reference
  and forms the 20-bit physical address handed to the bus control unit.
  assumes the execute unit presents one request per cycle with valid set;
  the answer follows one clock later and holds until the next request.
*/
`timescale 1ns/1ps
`default_nettype none
module sagen_top (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  // from execute unit
  input  wire sagen_pkg::sagen_req_type  req_i,
  input  wire sagen_pkg::sagen_regs_type regs_i,
  input  wire sagen_pkg::sagen_segs_type segs_i,
  // to bus control unit
  output sagen_pkg::sagen_ans_type       ans_o
);
  sagen_pkg::sagen_ans_type ans;
  sagen_pkg::sagen_ans_type next_ans;
  sagen_pkg::sagen_seg_type sel_seg;
  logic [15:0] operand_offset;
  logic        frame_based;
  logic [15:0] offset;
  logic [15:0] seg_val;
  logic        ovr_ok;

  sagen_offset u_offset (
    .modrm_i       (req_i.modrm),
    .disp_i        (req_i.disp),
    .regs_i        (regs_i),
    .offset_o      (operand_offset),
    .frame_based_o (frame_based)
  );

  // ----------------------------------------------------------------
  // segment and offset selection
  // ----------------------------------------------------------------
  always_comb begin
    ovr_ok = 1'b0;
    sel_seg = sagen_pkg::SEG_DATA0;
    offset = operand_offset;
    unique case (req_i.kind)
      sagen_pkg::ACC_FETCH: begin
        sel_seg = sagen_pkg::SEG_CODE; // R1 R16
        offset = regs_i.fetch_pointer; // R1
      end
      sagen_pkg::ACC_STACK: begin
        sel_seg = sagen_pkg::SEG_STACK; // R3 R16
        offset = regs_i.stack_top_offset;
      end
      sagen_pkg::ACC_SRC_A: begin
        sel_seg = sagen_pkg::SEG_DATA0; // R6
        offset = regs_i.source_index_reg; // R6
        ovr_ok = 1'b1;
      end
      sagen_pkg::ACC_DST_B: begin
        sel_seg = sagen_pkg::SEG_DATA1; // R8 R16
        offset = regs_i.dest_index_reg; // R8
      end
      sagen_pkg::ACC_OPERAND: begin
        sel_seg = frame_based ? sagen_pkg::SEG_STACK : sagen_pkg::SEG_DATA0; // R3 R5
        ovr_ok = 1'b1;
      end
      default: begin
        sel_seg = sagen_pkg::SEG_DATA0;
      end
    endcase
    if (ovr_ok && req_i.ovr_valid) begin
      sel_seg = req_i.ovr_seg; // R2 R4 R7 R9
    end
    unique case (sel_seg)
      sagen_pkg::SEG_CODE:  seg_val = segs_i.code_seg_base;
      sagen_pkg::SEG_STACK: seg_val = segs_i.stack_seg_base;
      sagen_pkg::SEG_DATA0: seg_val = segs_i.data0_seg_base;
      sagen_pkg::SEG_DATA1: seg_val = segs_i.data1_seg_base;
    endcase
    next_ans = ans;
    next_ans.valid = req_i.valid;
    if (req_i.valid) begin
      next_ans.seg = sel_seg;
      next_ans.offset = offset; // R10
      // unsigned base on 16-byte boundary plus unsigned offset, 20 bits
      next_ans.phys = 20'({seg_val, 4'h0} + {4'h0, offset}); // R14 R15 R17
    end
  end

  // ----------------------------------------------------------------
  // answer register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ans <= '0;
    end else begin
      ans <= next_ans;
    end
  end

  assign ans_o = ans;
endmodule
`default_nettype wire

// ===== include/sagen_pkg.sv
/*
  package for the segment address generator: segment selection codes,
  access kinds, addressing-mode field layout and request/answer structs.
  assumes the execute unit decodes prefixes and the second instruction byte.
*/
// How it works
// R1: instruction fetches use code segment base with fetch pointer as offset.
// R2: code-segment override applies to general variable and group A source accesses.
// R3: stack segment for stack-pointer accesses and default for frame-base offsets.
// R4: stack-segment override applies to general variable and group A source accesses.
// R5: offsets without frame base as base default to data segment 0.
// R6: group A source data uses data segment 0 with source index offset.
// R7: data-0 override replaces stack segment for frame-based offsets.
// R8: group B destination uses data segment 1 with destination index offset.
// R9: data-1 override applies to general variable and group A source accesses.
// R10: operand offset is unsigned 16 bits from selected segment base.
// R11: offset computation chosen by second instruction byte addressing field.
// R12: offset is displacement plus base plus index, any combination.
// R13: displacement is 8-bit or 16-bit immediate.
// R14: segment bases lie on any 16-byte boundary.
// R15: physical address is segment value shifted left four plus offset.
// R16: overrides ignored for fetch, stack-pointer and group B destination accesses.
// R17: physical addresses are 20 bits wide.
// R18: carry out of bit 15 discarded; offset wraps within segment.
`default_nettype none
package sagen_pkg;
  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int WORD_W = 16;
  localparam int PHYS_W = 20;
  localparam int SEG_SHIFT = 4;

  // ----------------------------------------------------------------
  // segment codes and access kinds
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SEG_DATA1 = 2'b00,
    SEG_CODE  = 2'b01,
    SEG_STACK = 2'b10,
    SEG_DATA0 = 2'b11
  } sagen_seg_type;

  typedef enum logic [2:0] {
    ACC_FETCH   = 3'b000,
    ACC_STACK   = 3'b001,
    ACC_OPERAND = 3'b010,
    ACC_SRC_A   = 3'b011,
    ACC_DST_B   = 3'b100
  } sagen_acc_type;

  // ----------------------------------------------------------------
  // second-byte field layout: mode [7:6], r/m [2:0]
  // ----------------------------------------------------------------
  localparam int MOD_HI = 7;
  localparam int MOD_LO = 6;
  localparam int RM_HI  = 2;
  localparam int RM_LO  = 0;
  localparam logic [1:0] MOD_NODISP = 2'h0;
  localparam logic [1:0] MOD_DISP8  = 2'h1;
  localparam logic [1:0] MOD_DISP16 = 2'h2;
  localparam logic [2:0] RM_DIRECT  = 3'h6;

  typedef struct packed {
    logic [15:0] base_reg;       // general base register value
    logic [15:0] frame_base_reg;
    logic [15:0] source_index_reg;
    logic [15:0] dest_index_reg;
    logic [15:0] stack_top_offset;
    logic [15:0] fetch_pointer;
  } sagen_regs_type;

  typedef struct packed {
    logic [15:0] code_seg_base;
    logic [15:0] stack_seg_base;
    logic [15:0] data0_seg_base;
    logic [15:0] data1_seg_base;
  } sagen_segs_type;

  typedef struct packed {
    logic          valid;
    sagen_acc_type kind;
    logic [7:0]    modrm;
    logic [15:0]   disp;       // low byte only used for 8-bit displacement
    logic          ovr_valid;
    sagen_seg_type ovr_seg;
  } sagen_req_type;

  typedef struct packed {
    logic          valid;
    sagen_seg_type seg;
    logic [15:0]   offset;
    logic [19:0]   phys;
  } sagen_ans_type;
endpackage
`default_nettype wire
